// ---- rtl/eeprom_consts.svh ----
/*
 * constants of the two-wire serial memory slave: device code, address
 * and page geometry, write cycle timing.
 * assumes the core clock period below matches the real core clock.
 */
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH

// ****************************************************************
// addressing
// ****************************************************************
`define DEV_TYPE_CODE        4'ha
`define ADDR_BITS            15
`define PAGE_OFF_BITS        6
`define PAGE_BYTES           64
`define FIFO_DEPTH           2

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS        4
`define WRITE_CYCLE_TIME_MS  5
// longest time, so rounded down
`define WRITE_CYCLE_CYCLES   ((`WRITE_CYCLE_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// ---- rtl/eeprom_pkg.sv ----
/*
 * types of the two-wire serial memory slave.
 * assumes eeprom_consts.svh is on the include path.
 */
`default_nettype none
`include "eeprom_consts.svh"

package eeprom_pkg;

	// ****************************************************************
	// link states and byte phases
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RX   = 3'h1,
		ST_ACK  = 3'h2,
		ST_TX   = 3'h3,
		ST_MACK = 3'h4
	} link_state_e;

	typedef enum logic [1:0] {
		PH_CTRL    = 2'h0,
		PH_ADDR_HI = 2'h1,
		PH_ADDR_LO = 2'h2,
		PH_DATA    = 2'h3
	} byte_phase_e;

	typedef struct packed {
		logic [`PAGE_OFF_BITS-1:0] off;
		logic [7:0]                data;
	} wr_entry_s;

endpackage : eeprom_pkg

`default_nettype wire

// ---- rtl/ram_if.sv ----
/*
 * ram port bundle: one write port, one registered read port.
 * assumes a single clock shared by user and memory.
 */
`timescale 1ns/1ps
`default_nettype none

interface ram_if #(
	parameter int AW = 15,
	parameter int DW = 8
);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;

	modport user (output we, output waddr, output wdata, output raddr,
		input rdata);
	modport mem (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface : ram_if

`default_nettype wire

// ---- rtl/ram_core.sv ----
/*
 * simple dual port memory, read data from a register.
 * assumes the user holds raddr one cycle before using rdata.
 */
`timescale 1ns/1ps
`default_nettype none

module ram_core #(
	parameter int AW = 15,
	parameter int DW = 8
) (
	input wire logic core_clk_i,
	ram_if.mem       port_m
);
	// no reset: contents are nonvolatile by intent
	logic [DW-1:0] mem_reg [0:(1<<AW)-1];
	logic [DW-1:0] rdata_reg;

	always_ff @(posedge core_clk_i) begin
		if (port_m.we) begin
			mem_reg[port_m.waddr] <= port_m.wdata;
		end
	end

	always_ff @(posedge core_clk_i) begin
		rdata_reg <= mem_reg[port_m.raddr];
	end

	assign port_m.rdata = rdata_reg;

endmodule : ram_core

`default_nettype wire

// ---- rtl/eeprom_slave.sv ----
/*
 * two-wire slave engine of a 32k x 8 serial memory: control byte
 * decode, word address, page buffered writes, self-timed write cycle,
 * current, random and sequential reads.
 * assumes scl and sda come from pins (synchronised here), the link is
 * much slower than the core clock, and sda is open drain outside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_consts.svh"

// How it works
// (RL1) control byte follows start; upper nibble must be binary 1010.
// (RL2) next three bits must equal the chip select pins to respond.
// (RL3) last control bit: 1 means read, 0 means write.
// (RL4) two address bytes follow, high first; only bits 14..0 kept.
// (RL5) on a matching control byte acknowledge, then read or write.
// (RL6) in writes acknowledge every byte in the ninth clock.
// (RL7) stop after data starts the write cycle; no acks until done.
// (RL8) write protect high: acknowledge all, store nothing, stay ready.
// (RL9) write protect sampled at stop; later changes do not matter.
// (RL10) after a byte write pointer holds the next address.
// (RL11) up to 63 more bytes buffered, committed only after stop.
// (RL12) only low six pointer bits count; overflow wraps in the page.
// (RL13) short writes rewrite whole page, untouched bytes kept.
// (RL14) master polls with start and write control byte until acked.
// (RL15) read without address returns byte one above last accessed.
// (RL16) master ends a read by not acknowledging, then stop.
// (RL17) random read: address loaded before repeated start abandons.
// (RL18) master ack after a read byte brings the next byte.
// (RL19) read pointer counts by one, wrapping 7fff to 0000.
// (RL20) sda fall with scl high is start, sda rise is stop.
// (RL21) on master nack the device releases sda high.
// (RL22) mismatched control byte gets no ack; ignore until start.
// (RL23) write cycle length is a parameter counted on core clock.
module eeprom_slave #(
	parameter int WC_CYCLES = `WRITE_CYCLE_CYCLES,
	parameter int ADDR_W    = `ADDR_BITS,
	parameter int PAGE_W    = `PAGE_OFF_BITS
) (
	input  wire logic core_clk_i,
	input  wire logic nrst_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output var  logic sda_o,
	output var  logic sda_oe_o,
	input  wire logic chip_select_bit0_i,
	input  wire logic chip_select_bit1_i,
	input  wire logic chip_select_bit2_i,
	input  wire logic write_protect_i,
	output var  logic write_busy_o
);
	localparam int WC_W = $clog2(WC_CYCLES + 1);
	localparam int PG_N = 1 << PAGE_W;

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [5:0]               pin_raw;
	logic [5:0]               sync1_reg;
	logic [5:0]               sync2_reg;
	logic                     scl_d_reg;
	logic                     sda_d_reg;
	logic                     scl_s;
	logic                     sda_s;
	logic                     wp_s;
	logic [2:0]               cs_s;
	logic                     scl_rise;
	logic                     scl_fall;
	logic                     start_det;
	logic                     stop_det;
	eeprom_pkg::link_state_e  st_reg;
	eeprom_pkg::byte_phase_e  phase_reg;
	logic [2:0]               bit_cnt_reg;
	logic                     byte_rdy_reg;
	logic [7:0]               shift_reg;
	logic [7:0]               tx_reg;
	logic                     next_tx_reg;
	logic                     sda_oe_reg;
	logic                     sda_o_reg;
	logic [ADDR_W-1:0]        ptr_reg;
	logic [ADDR_W-PAGE_W-1:0] ptr_page;
	logic [PAGE_W-1:0]        ptr_off;
	logic                     eval;
	logic                     ctrl_match;
	logic                     rx_accept;
	logic                     push;
	logic                     pop;
	logic                     have_data_reg;
	logic                     wr_go;
	logic                     wr_drop;
	logic                     busy_reg;
	logic [WC_W-1:0]          wc_cnt_reg;
	logic                     wc_last;
	logic [ADDR_W-PAGE_W-1:0] cpage_reg;
	logic [PAGE_W:0]          cidx_reg;
	logic                     commit_run;
	logic                     cmt_v_reg;
	logic [PAGE_W-1:0]        cmt_idx_reg;
	logic [PG_N-1:0]          mask_reg;
	logic                     mask_clr;
	eeprom_pkg::wr_entry_s    fifo_reg [0:`FIFO_DEPTH-1];
	logic [1:0]               f_cnt_reg;
	logic                     f_wp_reg;
	logic                     f_rp_reg;
	logic                     f_in_ready;
	logic                     f_out_valid;
	logic                     f_out_ready;
	eeprom_pkg::wr_entry_s    f_head;
	logic [7:0]               arr_rdata;

	ram_if #(.AW(ADDR_W), .DW(8)) arr_bus ();
	ram_if #(.AW(PAGE_W), .DW(8)) pg_bus ();

	// ****************************************************************
	// pin synchronisers and bus conditions
	// ****************************************************************
	assign pin_raw = {write_protect_i, chip_select_bit2_i,
		chip_select_bit1_i, chip_select_bit0_i, sda_i, scl_i};

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_reg <= 6'h03;
			sync2_reg <= 6'h03;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			scl_d_reg <= sync2_reg[0];
			sda_d_reg <= sync2_reg[1];
		end
	end

	assign scl_s     = sync2_reg[0];
	assign sda_s     = sync2_reg[1];
	assign cs_s      = sync2_reg[4:2];
	assign wp_s      = sync2_reg[5];
	assign scl_rise  = scl_s & ~scl_d_reg;
	assign scl_fall  = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s; // [RL20]
	assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s; // [RL20]

	// ****************************************************************
	// byte decode
	// ****************************************************************
	assign eval = (st_reg == eeprom_pkg::ST_RX) & byte_rdy_reg & scl_fall;
	assign ctrl_match = (shift_reg[7:4] == `DEV_TYPE_CODE) // [RL1]
		& (shift_reg[3:1] == cs_s); // [RL2]
	assign ptr_page = ptr_reg[ADDR_W-1:PAGE_W];
	assign ptr_off  = ptr_reg[PAGE_W-1:0];

	always_comb begin
		unique case (phase_reg)
			eeprom_pkg::PH_CTRL: rx_accept = ctrl_match & ~busy_reg; // [RL7]
			eeprom_pkg::PH_DATA: rx_accept = f_in_ready;
			default:             rx_accept = 1'b1;
		endcase
	end

	assign push = eval & rx_accept & (phase_reg == eeprom_pkg::PH_DATA);

	// ****************************************************************
	// link state machine
	// ****************************************************************
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_reg       <= eeprom_pkg::ST_IDLE;
			phase_reg    <= eeprom_pkg::PH_CTRL;
			bit_cnt_reg  <= 3'h0;
			byte_rdy_reg <= 1'b0;
			shift_reg    <= 8'h00;
			tx_reg       <= 8'h00;
			next_tx_reg  <= 1'b0;
			sda_oe_reg   <= 1'b0;
		end else if (start_det) begin
			st_reg       <= eeprom_pkg::ST_RX; // [RL1]
			phase_reg    <= eeprom_pkg::PH_CTRL;
			bit_cnt_reg  <= 3'h0;
			byte_rdy_reg <= 1'b0;
			sda_oe_reg   <= 1'b0;
		end else if (stop_det) begin
			st_reg     <= eeprom_pkg::ST_IDLE;
			sda_oe_reg <= 1'b0;
		end else begin
			unique case (st_reg)
				eeprom_pkg::ST_IDLE: begin
					sda_oe_reg <= 1'b0; // [RL22]
				end
				eeprom_pkg::ST_RX: begin
					if (scl_rise) begin
						shift_reg   <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						if (bit_cnt_reg == 3'h7) begin
							byte_rdy_reg <= 1'b1;
						end
					end else if (eval) begin
						byte_rdy_reg <= 1'b0;
						if (rx_accept) begin
							st_reg      <= eeprom_pkg::ST_ACK; // [RL5] [RL6]
							sda_oe_reg  <= 1'b1;
							next_tx_reg <= (phase_reg == eeprom_pkg::PH_CTRL)
								& shift_reg[0]; // [RL3]
							if (phase_reg != eeprom_pkg::PH_DATA) begin
								phase_reg <= eeprom_pkg::byte_phase_e'(
									phase_reg + 2'h1);
							end
						end else begin
							// mismatch, busy or full: silent to next start
							st_reg <= eeprom_pkg::ST_IDLE; // [RL22] [RL7]
						end
					end
				end
				eeprom_pkg::ST_ACK: begin
					if (scl_fall) begin
						bit_cnt_reg <= 3'h0;
						if (next_tx_reg) begin
							st_reg     <= eeprom_pkg::ST_TX; // [RL15] [RL18]
							tx_reg     <= arr_rdata;
							sda_oe_reg <= ~arr_rdata[7];
						end else begin
							st_reg     <= eeprom_pkg::ST_RX;
							sda_oe_reg <= 1'b0;
						end
					end
				end
				eeprom_pkg::ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_reg == 3'h7) begin
							st_reg     <= eeprom_pkg::ST_MACK;
							sda_oe_reg <= 1'b0;
						end else begin
							tx_reg      <= {tx_reg[6:0], 1'b0};
							sda_oe_reg  <= ~tx_reg[6];
							bit_cnt_reg <= bit_cnt_reg + 3'h1;
						end
					end
				end
				eeprom_pkg::ST_MACK: begin
					if (scl_rise) begin
						next_tx_reg <= 1'b1;
						if (sda_s) begin
							st_reg <= eeprom_pkg::ST_IDLE; // [RL16] [RL21]
						end else begin
							st_reg <= eeprom_pkg::ST_ACK; // [RL18]
						end
					end
				end
				default: begin
					st_reg     <= eeprom_pkg::ST_IDLE;
					sda_oe_reg <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// address pointer
	// ****************************************************************
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ptr_reg <= '0;
		end else if (eval & rx_accept) begin
			unique case (phase_reg)
				eeprom_pkg::PH_ADDR_HI: begin
					// the top bit of the high byte is dropped
					ptr_reg[ADDR_W-1:8] <= shift_reg[ADDR_W-9:0]; // [RL4]
				end
				eeprom_pkg::PH_ADDR_LO: begin
					ptr_reg[7:0] <= shift_reg; // [RL4] [RL17]
				end
				eeprom_pkg::PH_DATA: begin
					ptr_reg <= {ptr_page, PAGE_W'(ptr_off + 1)}; // [RL10] [RL12]
				end
				default: begin
					ptr_reg <= ptr_reg;
				end
			endcase
		end else if ((st_reg == eeprom_pkg::ST_MACK) & scl_rise) begin
			ptr_reg <= ADDR_W'(ptr_reg + 1); // [RL15] [RL19]
		end
	end

	// ****************************************************************
	// two-entry buffer between receiver and page buffer
	// ****************************************************************
	assign f_in_ready  = (f_cnt_reg != 2'h2);
	assign f_out_valid = (f_cnt_reg != 2'h0);
	assign f_out_ready = ~busy_reg;
	assign pop         = f_out_valid & f_out_ready;
	assign f_head      = fifo_reg[f_rp_reg];

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			fifo_reg[f_wp_reg] <= '{off: ptr_off, data: shift_reg};
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			f_cnt_reg <= 2'h0;
			f_wp_reg  <= 1'b0;
			f_rp_reg  <= 1'b0;
		end else begin
			f_cnt_reg <= 2'(f_cnt_reg + {1'b0, push} - {1'b0, pop});
			f_wp_reg  <= f_wp_reg ^ push;
			f_rp_reg  <= f_rp_reg ^ pop;
		end
	end

	// ****************************************************************
	// write command end and write cycle
	// ****************************************************************
	assign wr_go    = stop_det & have_data_reg & ~wp_s; // [RL7] [RL9]
	assign wr_drop  = (stop_det & have_data_reg & wp_s) // [RL8]
		| (start_det & have_data_reg);
	assign wc_last  = busy_reg & (wc_cnt_reg == WC_W'(WC_CYCLES - 1));
	assign mask_clr = wc_last | wr_drop;
	assign commit_run = busy_reg & ~f_out_valid
		& (cidx_reg < (PAGE_W+1)'(PG_N));

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			have_data_reg <= 1'b0;
		end else if (push) begin
			have_data_reg <= 1'b1; // [RL11]
		end else if (stop_det | start_det) begin
			have_data_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			busy_reg   <= 1'b0;
			wc_cnt_reg <= '0;
			cpage_reg  <= '0;
			cidx_reg   <= '0;
		end else if (wr_go) begin
			busy_reg   <= 1'b1; // [RL7]
			wc_cnt_reg <= '0;
			cpage_reg  <= ptr_page;
			cidx_reg   <= '0;
		end else if (busy_reg) begin
			wc_cnt_reg <= WC_W'(wc_cnt_reg + 1); // [RL23]
			if (wc_last) begin
				busy_reg <= 1'b0; // [RL23]
			end
			if (commit_run) begin
				cidx_reg <= (PAGE_W+1)'(cidx_reg + 1);
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmt_v_reg   <= 1'b0;
			cmt_idx_reg <= '0;
		end else begin
			cmt_v_reg   <= commit_run;
			cmt_idx_reg <= cidx_reg[PAGE_W-1:0];
		end
	end

	// one valid bit per page byte
	for (genvar g = 0; g < PG_N; g++) begin : g_mask
		always_ff @(posedge core_clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				mask_reg[g] <= 1'b0;
			end else if (pop & (f_head.off == PAGE_W'(g))) begin
				mask_reg[g] <= 1'b1; // [RL12]
			end else if (mask_clr) begin
				mask_reg[g] <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// page buffer and array
	// ****************************************************************
	assign pg_bus.we     = pop;
	assign pg_bus.waddr  = f_head.off;
	assign pg_bus.wdata  = f_head.data;
	assign pg_bus.raddr  = cidx_reg[PAGE_W-1:0];
	// unwritten bytes keep their contents, as a full page refresh would
	assign arr_bus.we    = cmt_v_reg & mask_reg[cmt_idx_reg]; // [RL13]
	assign arr_bus.waddr = {cpage_reg, cmt_idx_reg};
	assign arr_bus.wdata = pg_bus.rdata;
	assign arr_bus.raddr = ptr_reg;
	assign arr_rdata     = arr_bus.rdata;

	ram_core #(.AW(PAGE_W), .DW(8)) u_page (
		.core_clk_i (core_clk_i),
		.port_m     (pg_bus)
	);

	ram_core #(.AW(ADDR_W), .DW(8)) u_array (
		.core_clk_i (core_clk_i),
		.port_m     (arr_bus)
	);

	// ****************************************************************
	// outputs
	// ****************************************************************
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sda_o_reg <= 1'b0;
		end else begin
			sda_o_reg <= 1'b0;
		end
	end

	assign sda_o        = sda_o_reg;
	assign sda_oe_o     = sda_oe_reg;
	assign write_busy_o = busy_reg;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	a_ctrl_ack_match: assert property ( // [RL1] [RL5]
		eval && phase_reg == eeprom_pkg::PH_CTRL && ctrl_match && !busy_reg
		|=> st_reg == eeprom_pkg::ST_ACK && sda_oe_reg)
		else $error("matching control byte not acknowledged");
	a_ctrl_no_match: assert property ( // [RL2] [RL22]
		eval && phase_reg == eeprom_pkg::PH_CTRL && !ctrl_match
		|=> st_reg == eeprom_pkg::ST_IDLE && !sda_oe_reg)
		else $error("foreign control byte acknowledged");
	a_busy_silent: assert property ( // [RL7]
		eval && phase_reg == eeprom_pkg::PH_CTRL && busy_reg
		|=> !sda_oe_reg [*2])
		else $error("acknowledge during write cycle");
	a_write_byte_ack: assert property ( // [RL6]
		eval && phase_reg != eeprom_pkg::PH_CTRL && f_in_ready
		|=> sda_oe_reg && st_reg == eeprom_pkg::ST_ACK)
		else $error("write byte not acknowledged");
	a_wp_blocks: assert property ( // [RL8]
		stop_det && have_data_reg && wp_s
		|=> !busy_reg && !have_data_reg && mask_reg == '0)
		else $error("protected write started a cycle");
	a_wc_start: assert property ( // [RL9]
		stop_det && have_data_reg && !wp_s
		|=> busy_reg && cpage_reg == $past(ptr_page))
		else $error("write cycle not started at stop");
	a_page_wrap: assert property ( // [RL12]
		push |=> ptr_page == $past(ptr_page)
		&& ptr_off == PAGE_W'($past(ptr_off) + 1))
		else $error("page pointer did not wrap within page");
	a_read_inc: assert property ( // [RL19]
		st_reg == eeprom_pkg::ST_MACK && scl_rise
		|=> ptr_reg == ADDR_W'($past(ptr_reg) + 1))
		else $error("read pointer not advanced");
	a_read_release: assert property ( // [RL21]
		st_reg == eeprom_pkg::ST_MACK && scl_rise && sda_s
		|=> st_reg == eeprom_pkg::ST_IDLE && !sda_oe_reg)
		else $error("sda not released after master nack");
	a_tx_load: assert property ( // [RL18]
		st_reg == eeprom_pkg::ST_ACK && next_tx_reg && scl_fall
		|=> st_reg == eeprom_pkg::ST_TX && tx_reg == $past(arr_rdata))
		else $error("read byte not loaded");
	a_wc_end: assert property ( // [RL23]
		wc_last |=> !busy_reg)
		else $error("write cycle overran its count");

	c_page_write: cover property (push ##[1:1000] push);
	c_seq_read: cover property (st_reg == eeprom_pkg::ST_MACK && scl_rise
		&& !sda_s);
	c_wp_block: cover property (stop_det && have_data_reg && wp_s);
	c_commit: cover property (arr_bus.we);

endmodule : eeprom_slave

`default_nettype wire

// ---- tb/bus_master_model.sv ----
/*
 * behavioural two-wire bus master: start, stop, byte out, byte in.
 * assumes the bench resolves sda with a pull-up and feeds it back here.
 */
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output var  logic scl_o,
	output var  logic sda_oe_o
);
	// ****************************************************************
	// bus phases, quarter period of 5 core cycles (80 ns scl)
	// ****************************************************************
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end

	task automatic q();
		repeat (5) @(negedge clk_i);
	endtask : q

	// also serves as repeated start: sda is released first, then scl is raised
	task automatic start();
		sda_oe_o = 1'b0;
		q();
		scl_o = 1'b1;
		q();
		sda_oe_o = 1'b1;
		q();
		scl_o = 1'b0;
		q();
	endtask : start

	// scl rests high after stop, no free running clock
	task automatic stop();
		sda_oe_o = 1'b1;
		q();
		scl_o = 1'b1;
		q();
		sda_oe_o = 1'b0;
		q();
		q();
	endtask : stop

	// sda changes only while scl is low
	task automatic xfer(input logic b, output logic r);
		sda_oe_o = ~b;
		q();
		scl_o = 1'b1;
		q();
		r = sda_i;
		q();
		scl_o = 1'b0;
		q();
	endtask : xfer

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) xfer(d[i], r);
		xfer(1'b1, r);
		ack = ~r;
	endtask : wbyte

	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
		xfer(~ack, r);
	endtask : rbyte
endmodule : bus_master_model

`default_nettype wire

// ---- tb/test_serial_eeprom_slave_protocol.sv ----
/*
 * self-checking bench of the two-wire memory slave.
 * assumes the rtl files and bus_master_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module test_serial_eeprom_slave_protocol;
	// ****************************************************************
	// harness
	// ****************************************************************
	localparam int WC = 200;
	logic       core_clk = 1'b0;
	logic       nrst     = 1'b0;
	logic       wp       = 1'b0;
	logic [2:0] cs       = 3'h5;
	logic       scl;
	logic       m_oe;
	logic       d_o;
	logic       d_oe;
	logic       busy;
	logic       sda;
	logic       busy_prev = 1'b0;
	int         busy_len = 0;
	int         errors   = 0;
	int         tests_run = 0;

	assign sda = (d_oe ? d_o : 1'b1) & ~m_oe;
	always #2 core_clk = ~core_clk;
	// sampled on the falling edge, away from the edge that updates busy;
	// the count restarts by itself at each rise, so one process owns it
	always @(negedge core_clk) begin
		busy_prev <= busy;
		if (busy === 1'b1)
			busy_len <= (busy_prev === 1'b1) ? busy_len + 1 : 1;
	end

	eeprom_slave #(.WC_CYCLES(WC)) eeprom_slave_inst (
		.core_clk_i(core_clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda),
		.sda_o(d_o), .sda_oe_o(d_oe), .chip_select_bit0_i(cs[0]),
		.chip_select_bit1_i(cs[1]), .chip_select_bit2_i(cs[2]),
		.write_protect_i(wp), .write_busy_o(busy));
	bus_master_model bus_master_model_inst (.clk_i(core_clk),
		.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

	task automatic end_of_test();
		if (errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic send(input logic [7:0] d, input logic exp);
		logic a;
		bus_master_model_inst.wbyte(d, a);
		chk({15'h0, a}, {15'h0, exp});
	endtask : send

	task automatic rd(input logic ack, input logic [7:0] exp);
		logic [7:0] d;
		bus_master_model_inst.rbyte(ack, d);
		chk({8'h0, d}, {8'h0, exp});
	endtask : rd

	// control byte is 1010, selects 101, then direction
	task automatic hdr(input logic [15:0] a);
		bus_master_model_inst.start();
		send(8'haa, 1'b1);
		send(a[15:8], 1'b1);
		send(a[7:0], 1'b1);
	endtask : hdr

	task automatic rd_start();
		bus_master_model_inst.start();
		send(8'hab, 1'b1);
	endtask : rd_start

	// polling fits inside the short write cycle, so first poll is refused
	task automatic wr_end();
		bus_master_model_inst.stop();
		chk({15'h0, busy}, 16'h1);
		bus_master_model_inst.start();
		send(8'haa, 1'b0);
		bus_master_model_inst.stop();
		for (int n = 0; n < 1000 && busy !== 1'b0; n++)
			@(negedge core_clk);
		chk(16'(busy_len), 16'(WC));
		bus_master_model_inst.start();
		send(8'haa, 1'b1);
		bus_master_model_inst.stop();
	endtask : wr_end

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset();
		chk({14'h0, busy, d_oe}, 16'h0);
	endtask : t_reset

	task automatic t_bad_ctrl();
		bus_master_model_inst.start();
		send(8'hba, 1'b0);
		send(8'haa, 1'b0);
		bus_master_model_inst.stop();
		bus_master_model_inst.start();
		send(8'ha8, 1'b0);
		bus_master_model_inst.stop();
	endtask : t_bad_ctrl

	task automatic t_ptr();
		hdr(16'h8000);
		send(8'h11, 1'b1);
		send(8'h22, 1'b1);
		wr_end();
		hdr(16'h0000);
		send(8'h33, 1'b1);
		wr_end();
		rd_start();
		rd(1'b0, 8'h22);
		chk({15'h0, d_oe}, 16'h0);
		bus_master_model_inst.stop();
	endtask : t_ptr

	task automatic t_wrap();
		hdr(16'h7ffe);
		send(8'h44, 1'b1);
		send(8'h55, 1'b1);
		send(8'h66, 1'b1);
		wr_end();
		hdr(16'h7ffe);
		rd_start();
		rd(1'b1, 8'h44);
		rd(1'b1, 8'h55);
		rd(1'b1, 8'h33);
		rd(1'b0, 8'h22);
		bus_master_model_inst.stop();
		hdr(16'h7fc0);
		rd_start();
		rd(1'b0, 8'h66);
		bus_master_model_inst.stop();
	endtask : t_wrap

	task automatic t_protect();
		wp = 1'b1;
		hdr(16'h0000);
		send(8'hee, 1'b1);
		bus_master_model_inst.stop();
		repeat (8) @(negedge core_clk);
		chk({15'h0, busy}, 16'h0);
		bus_master_model_inst.start();
		send(8'haa, 1'b1);
		bus_master_model_inst.stop();
		wp = 1'b0;
		hdr(16'h0001);
		send(8'h77, 1'b1);
		// protect raised mid cycle must not cancel it
		fork
			begin
				repeat (30) @(negedge core_clk);
				wp = 1'b1;
			end
		join_none
		wr_end();
		wp = 1'b0;
		hdr(16'h0000);
		rd_start();
		rd(1'b1, 8'h33);
		rd(1'b0, 8'h77);
		bus_master_model_inst.stop();
	endtask : t_protect

	initial begin
		repeat (8) @(negedge core_clk);
		nrst = 1'b1;
		t_reset();
		repeat (6) @(negedge core_clk);
		t_bad_ctrl();
		t_ptr();
		t_wrap();
		t_protect();
		end_of_test();
	end

	// normal run is near 44 us
	initial begin
		#300000;
		errors++;
		end_of_test();
	end
endmodule : test_serial_eeprom_slave_protocol

`default_nettype wire
